/* smbus_cmd_pkg.sv */
// constants and types shared by the slave smbus command decoder
`default_nettype none
package smbus_cmd_pkg;
  // ---------------------------------------------------------------
  // frame geometry
  // ---------------------------------------------------------------
  localparam int FRAME_BYTES = 9;
  localparam int RESP_BYTES = 8;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  // ---------------------------------------------------------------
  // command code byte fields
  // ---------------------------------------------------------------
  localparam int CC_FUNC_LSB = 2;
  localparam int CC_SIZE_LSB = 5;
  localparam logic [2:0] FUNC_CSR = 3'h0;
  localparam logic [2:0] FUNC_EEPROM = 3'h1;
  localparam logic [1:0] SIZE_BLOCK = 2'h2;
  // ---------------------------------------------------------------
  // csr command byte fields
  // ---------------------------------------------------------------
  localparam int CSR_OP_BIT = 4;
  localparam int CSR_RD_FLAG_BIT = 6;
  localparam int CSR_WR_FLAG_BIT = 7;
  localparam logic [7:0] CSR_REPLY_COUNT = 8'h07;
  localparam logic [3:0] CSR_REPLY_LEN = 4'h8;
  // ---------------------------------------------------------------
  // eeprom command byte fields
  // ---------------------------------------------------------------
  localparam int EE_OP_BIT = 0;
  localparam int EE_OVR_BIT = 1;
  localparam int EE_NACK_BIT = 3;
  localparam int EE_ARB_BIT = 4;
  localparam int EE_OTHER_BIT = 5;
  localparam logic [7:0] EE_REPLY_COUNT = 8'h05;
  localparam logic [3:0] EE_REPLY_LEN = 4'h6;
  localparam logic [4:0] ARB_LOSS_LIMIT = 5'h10;
  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [4:0] ARB_COUNT_RESET = 5'h00;
  // ---------------------------------------------------------------
  // decoder states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DECODE = 3'b001,
    ST_CSR = 3'b010,
    ST_EE = 3'b011,
    ST_REPLY = 3'b100
  } state_t;
endpackage
`default_nettype wire

/* bit_sync.sv */
// two-flop synchroniser for independent level or toggle bits
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

/* link_frame.sv */
// link-clock side: frame capture, refusal and reply byte serving
`default_nettype none
module link_frame (
  input wire logic link_clk,
  input wire logic link_reset_n,
  input wire logic frame_start,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic frame_stop,
  input wire logic tx_req,
  input wire logic done_toggle,
  input wire logic [63:0] resp_flat,
  input wire logic [3:0] resp_len,
  input wire logic [3:0] resp_cmd_idx,
  output logic rx_nack,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_nack,
  output logic req_toggle,
  output logic status_read_toggle,
  output logic [8*smbus_cmd_pkg::FRAME_BYTES-1:0] frame_flat
);
  logic done_seen;
  logic busy;
  logic [3:0] widx;
  logic [3:0] ridx;

  bit_sync #(.WIDTH(1)) u_done_sync (
    .clk(link_clk),
    .reset_n(link_reset_n),
    .d(done_toggle),
    .q(done_seen)
  );

  assign busy = req_toggle != done_seen;

  // ---------------------------------------------------------------
  // frame capture; bytes hold still while the decoder owns them
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      widx <= 4'h0;
      rx_nack <= 1'b0;
    end else if (frame_start) begin
      widx <= 4'h0;
      rx_nack <= busy;
    end else if (rx_valid && !rx_nack) begin
      if (widx == smbus_cmd_pkg::FRAME_LAST) begin
        rx_nack <= 1'b1;
      end else begin
        widx <= widx + 4'h1;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (rx_valid && !rx_nack && !frame_start &&
        widx != smbus_cmd_pkg::FRAME_LAST) begin
      frame_flat[{widx, 3'h0} +: 8] <= rx_byte;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      req_toggle <= 1'b0;
    end else if (frame_stop && !rx_nack && widx != 4'h0) begin
      req_toggle <= ~req_toggle;
    end
  end

  // ---------------------------------------------------------------
  // reply serving
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      ridx <= 4'h0;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
      tx_nack <= 1'b0;
      status_read_toggle <= 1'b0;
    end else begin
      tx_valid <= tx_req;
      if (frame_start) begin
        ridx <= 4'h0;
      end else if (tx_req) begin
        if (busy || ridx >= resp_len) begin
          tx_nack <= 1'b1;
          tx_byte <= 8'h00;
        end else begin
          tx_nack <= 1'b0;
          tx_byte <= resp_flat[{ridx[2:0], 3'h0} +: 8];
          ridx <= ridx + 4'h1;
          // status byte leaving the device is what clears its flags
          if (ridx == resp_cmd_idx) begin
            status_read_toggle <= ~status_read_toggle;
          end
        end
      end
    end
  end

  AST_BUSY_NACK: assert property (
    @(posedge link_clk) disable iff (!link_reset_n)
    frame_start && busy |=> rx_nack)
    else $error("frame started while busy was not refused");
endmodule
`default_nettype wire

/* smbus_slave_cmd_decode.sv */
// slave smbus command decoder for csr and serial eeprom access
`default_nettype none
// Notes on behaviour
// - csr command bits 0..3 enable data lanes 7:0 up to 31:24
// - csr command bit 4: zero writes, one reads
// - bit 6 flags an unclaimed latest csr read; cleared when read
// - bit 7 flags an unclaimed latest csr write; cleared when read
// - cleared csr flag means claimed only, not error free
// - eeprom frame: code, count, command, device, low, high, data
// - byte count present only in block transfers
// - device address used only with override; left justified
// - eeprom byte address is high byte over low byte
// - eeprom command: op 0, override 1, errors 3..5, zeros
// - command code bits 4:2 pick csr, eeprom or reserved
// - csr address low plus six upper bits, four data bytes
// - new command while busy or data unavailable is refused
// - eeprom errors: nack, sixteen lost arbitrations, misplaced
module smbus_slave_cmd_decode (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic link_reset_n,
  input wire logic frame_start,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic frame_stop,
  input wire logic tx_req,
  output logic rx_nack,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_nack,
  output logic csr_req,
  output logic csr_read,
  output logic [13:0] csr_addr,
  output logic [3:0] csr_be,
  output logic [31:0] csr_wdata,
  input wire logic csr_done,
  input wire logic csr_claimed,
  input wire logic [31:0] csr_rdata,
  output logic ee_req,
  output logic ee_read,
  output logic [6:0] ee_dev_addr,
  output logic [15:0] ee_byte_addr,
  output logic [7:0] ee_wdata,
  input wire logic ee_done,
  input wire logic ee_nack,
  input wire logic ee_misplaced,
  input wire logic ee_arb_lost,
  input wire logic ee_arb_won,
  input wire logic [7:0] ee_rdata,
  input wire logic [6:0] default_ee_addr,
  output logic unclaimed_read_flag,
  output logic unclaimed_write_flag,
  output logic no_ack_error,
  output logic lost_arbitration_error,
  output logic misplaced_condition_error,
  output logic cmd_busy
);
  smbus_cmd_pkg::state_t state;
  logic [8*smbus_cmd_pkg::FRAME_BYTES-1:0] frame_flat;
  logic req_toggle;
  logic status_read_toggle;
  logic [1:0] link_q;
  logic req_last;
  logic rd_last;
  logic new_frame;
  logic read_evt;
  logic done_toggle;
  logic [63:0] resp_flat;
  logic [3:0] resp_len;
  logic [3:0] resp_cmd_idx;
  logic resp_is_csr;
  logic block;
  logic ee_override;
  logic [7:0] ee_data;
  logic [31:0] csr_data;
  logic [4:0] arb_count;
  logic [7:0] command_code_byte;
  logic [2:0] family;
  logic [3:0] base;
  logic [7:0] cmd;
  logic [7:0] dec_b2;
  logic [7:0] dec_b3;
  logic [7:0] dec_b4;
  logic [31:0] dec_word;
  logic [31:0] be_mask;

  function automatic logic [7:0] fb(input logic [3:0] k);
    fb = frame_flat[{k, 3'h0} +: 8];
  endfunction

  // ---------------------------------------------------------------
  // link domain and crossings
  // ---------------------------------------------------------------
  link_frame u_link (
    .link_clk(link_clk),
    .link_reset_n(link_reset_n),
    .frame_start(frame_start),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .frame_stop(frame_stop),
    .tx_req(tx_req),
    .done_toggle(done_toggle),
    .resp_flat(resp_flat),
    .resp_len(resp_len),
    .resp_cmd_idx(resp_cmd_idx),
    .rx_nack(rx_nack),
    .tx_valid(tx_valid),
    .tx_byte(tx_byte),
    .tx_nack(tx_nack),
    .req_toggle(req_toggle),
    .status_read_toggle(status_read_toggle),
    .frame_flat(frame_flat)
  );

  // frame bytes are stable once the request toggle arrives
  bit_sync #(.WIDTH(2)) u_link_sync (
    .clk(ref_clk),
    .reset_n(reset_n),
    .d({status_read_toggle, req_toggle}),
    .q(link_q)
  );

  assign new_frame = link_q[0] != req_last;
  assign read_evt = link_q[1] != rd_last;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rd_last <= 1'b0;
    end else begin
      rd_last <= link_q[1];
    end
  end

  // ---------------------------------------------------------------
  // field extraction
  // ---------------------------------------------------------------
  assign command_code_byte = fb(4'h0);
  assign family = command_code_byte[smbus_cmd_pkg::CC_FUNC_LSB +: 3];
  assign block = command_code_byte[smbus_cmd_pkg::CC_SIZE_LSB +: 2] ==
                 smbus_cmd_pkg::SIZE_BLOCK;
  assign base = block ? 4'h1 : 4'h0;
  assign cmd = fb(base + 4'h1);
  assign dec_b2 = fb(base + 4'h2);
  assign dec_b3 = fb(base + 4'h3);
  assign dec_b4 = fb(base + 4'h4);
  assign dec_word = {fb(base + 4'h7), fb(base + 4'h6),
                     fb(base + 4'h5), dec_b4};
  assign be_mask = {{8{csr_be[3]}}, {8{csr_be[2]}},
                    {8{csr_be[1]}}, {8{csr_be[0]}}};

  // ---------------------------------------------------------------
  // command sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= smbus_cmd_pkg::ST_IDLE;
      req_last <= 1'b0;
      done_toggle <= 1'b0;
      cmd_busy <= 1'b0;
    end else begin
      case (state)
        smbus_cmd_pkg::ST_IDLE: begin
          if (new_frame) begin
            req_last <= link_q[0];
            cmd_busy <= 1'b1;
            state <= smbus_cmd_pkg::ST_DECODE;
          end
        end
        smbus_cmd_pkg::ST_DECODE: begin
          if (family == smbus_cmd_pkg::FUNC_CSR) begin
            state <= smbus_cmd_pkg::ST_CSR;
          end else if (family == smbus_cmd_pkg::FUNC_EEPROM) begin
            state <= smbus_cmd_pkg::ST_EE;
          end else begin
            state <= smbus_cmd_pkg::ST_REPLY;
          end
        end
        smbus_cmd_pkg::ST_CSR: begin
          if (csr_done) begin
            state <= smbus_cmd_pkg::ST_REPLY;
          end
        end
        smbus_cmd_pkg::ST_EE: begin
          if (ee_done) begin
            state <= smbus_cmd_pkg::ST_REPLY;
          end
        end
        smbus_cmd_pkg::ST_REPLY: begin
          done_toggle <= ~done_toggle;
          cmd_busy <= 1'b0;
          state <= smbus_cmd_pkg::ST_IDLE;
        end
        default: begin
          state <= smbus_cmd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // csr request; command bit 5 is deliberately not looked at
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      csr_req <= 1'b0;
      csr_read <= 1'b0;
      csr_addr <= 14'h0000;
      csr_be <= 4'h0;
      csr_wdata <= 32'h00000000;
      csr_data <= 32'h00000000;
    end else if (state == smbus_cmd_pkg::ST_DECODE &&
                 family == smbus_cmd_pkg::FUNC_CSR) begin
      csr_req <= 1'b1;
      csr_read <= cmd[smbus_cmd_pkg::CSR_OP_BIT];
      csr_addr <= {dec_b3[5:0], dec_b2};
      csr_be <= cmd[3:0];
      csr_wdata <= dec_word & {{8{cmd[3]}}, {8{cmd[2]}},
                               {8{cmd[1]}}, {8{cmd[0]}}};
      csr_data <= dec_word;
    end else if (state == smbus_cmd_pkg::ST_CSR && csr_done) begin
      csr_req <= 1'b0;
      if (csr_read) begin
        csr_data <= csr_rdata & be_mask;
      end
    end
  end

  // ---------------------------------------------------------------
  // eeprom request
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ee_req <= 1'b0;
      ee_read <= 1'b0;
      ee_override <= 1'b0;
      ee_dev_addr <= 7'h00;
      ee_byte_addr <= 16'h0000;
      ee_wdata <= 8'h00;
      ee_data <= 8'h00;
    end else if (state == smbus_cmd_pkg::ST_DECODE &&
                 family == smbus_cmd_pkg::FUNC_EEPROM) begin
      ee_req <= 1'b1;
      ee_read <= cmd[smbus_cmd_pkg::EE_OP_BIT];
      ee_override <= cmd[smbus_cmd_pkg::EE_OVR_BIT];
      ee_dev_addr <= cmd[smbus_cmd_pkg::EE_OVR_BIT] ?
                     dec_b2[7:1] : default_ee_addr;
      ee_byte_addr <= {dec_b4, dec_b3};
      ee_wdata <= fb(base + 4'h5);
      ee_data <= fb(base + 4'h5);
    end else if (state == smbus_cmd_pkg::ST_EE && ee_done) begin
      ee_req <= 1'b0;
      if (ee_read) begin
        ee_data <= ee_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // sticky error flags; a new event beats a clear in the same cycle
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      unclaimed_read_flag <= smbus_cmd_pkg::FLAG_RESET;
      unclaimed_write_flag <= smbus_cmd_pkg::FLAG_RESET;
    end else begin
      // only the claim is tracked, never the target's own status
      if (state == smbus_cmd_pkg::ST_CSR && csr_done && csr_read) begin
        unclaimed_read_flag <= !csr_claimed;
      end else if (read_evt && resp_is_csr) begin
        unclaimed_read_flag <= 1'b0;
      end
      if (state == smbus_cmd_pkg::ST_CSR && csr_done && !csr_read) begin
        unclaimed_write_flag <= !csr_claimed;
      end else if (read_evt && resp_is_csr) begin
        unclaimed_write_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      arb_count <= smbus_cmd_pkg::ARB_COUNT_RESET;
    end else if (ee_arb_won || state == smbus_cmd_pkg::ST_DECODE) begin
      arb_count <= smbus_cmd_pkg::ARB_COUNT_RESET;
    end else if (ee_arb_lost &&
                 arb_count != smbus_cmd_pkg::ARB_LOSS_LIMIT) begin
      arb_count <= arb_count + 5'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      no_ack_error <= smbus_cmd_pkg::FLAG_RESET;
      lost_arbitration_error <= smbus_cmd_pkg::FLAG_RESET;
      misplaced_condition_error <= smbus_cmd_pkg::FLAG_RESET;
    end else begin
      if (state == smbus_cmd_pkg::ST_EE && ee_nack) begin
        no_ack_error <= 1'b1;
      end else if (read_evt && !resp_is_csr) begin
        no_ack_error <= 1'b0;
      end
      if (arb_count == smbus_cmd_pkg::ARB_LOSS_LIMIT - 5'h01 &&
          ee_arb_lost && !ee_arb_won) begin
        lost_arbitration_error <= 1'b1;
      end else if (read_evt && !resp_is_csr) begin
        lost_arbitration_error <= 1'b0;
      end
      if (state == smbus_cmd_pkg::ST_EE && ee_misplaced) begin
        misplaced_condition_error <= 1'b1;
      end else if (read_evt && !resp_is_csr) begin
        misplaced_condition_error <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // reply image, held still until the next command reaches reply
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      resp_flat <= 64'h0;
      resp_len <= 4'h0;
      resp_cmd_idx <= 4'h1;
      resp_is_csr <= 1'b1;
    end else if (state == smbus_cmd_pkg::ST_REPLY) begin
      resp_is_csr <= family == smbus_cmd_pkg::FUNC_CSR;
      if (family == smbus_cmd_pkg::FUNC_CSR) begin
        resp_flat <= {csr_data, 2'h0, csr_addr,
                      unclaimed_write_flag, unclaimed_read_flag,
                      1'b0, csr_read, csr_be,
                      smbus_cmd_pkg::CSR_REPLY_COUNT} >> (block ? 0 : 8);
        resp_len <= smbus_cmd_pkg::CSR_REPLY_LEN - (block ? 4'h0 : 4'h1);
      end else if (family == smbus_cmd_pkg::FUNC_EEPROM) begin
        resp_flat <= {16'h0000, ee_data, ee_byte_addr,
                      ee_override ? {ee_dev_addr, 1'b0} : dec_b2,
                      2'b00, misplaced_condition_error,
                      lost_arbitration_error, no_ack_error,
                      1'b0, ee_override, ee_read,
                      smbus_cmd_pkg::EE_REPLY_COUNT} >> (block ? 0 : 8);
        resp_len <= smbus_cmd_pkg::EE_REPLY_LEN - (block ? 4'h0 : 4'h1);
      end else begin
        resp_flat <= 64'h0;
        resp_len <= 4'h0;
      end
      resp_cmd_idx <= block ? 4'h1 : 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_taken;
    state == smbus_cmd_pkg::ST_IDLE && new_frame;
  endsequence

  sequence s_csr_decode;
    state == smbus_cmd_pkg::ST_DECODE && family == smbus_cmd_pkg::FUNC_CSR;
  endsequence

  sequence s_ee_decode;
    state == smbus_cmd_pkg::ST_DECODE &&
    family == smbus_cmd_pkg::FUNC_EEPROM;
  endsequence

  AST_TAKEN_DECODED: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_taken |=> state == smbus_cmd_pkg::ST_DECODE ##1
                state != smbus_cmd_pkg::ST_IDLE)
    else $error("accepted frame was not decoded");

  AST_CSR_OP_SELECT: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_csr_decode |=> csr_req && csr_read == $past(cmd[4]))
    else $error("csr operation select mismatch");

  AST_CSR_LANES: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    csr_req |-> (csr_wdata & ~be_mask) == 32'h00000000)
    else $error("disabled lane carries write data");

  AST_UNCLAIMED_READ: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    state == smbus_cmd_pkg::ST_CSR && csr_done && csr_read
    |=> unclaimed_read_flag == !$past(csr_claimed))
    else $error("unclaimed read flag does not follow the claim");

  AST_UNCLAIMED_WRITE: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    state == smbus_cmd_pkg::ST_CSR && csr_done && !csr_read &&
    !csr_claimed |=> unclaimed_write_flag [*2])
    else $error("unclaimed write flag not set");

  AST_CLAIM_ONLY: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    state == smbus_cmd_pkg::ST_CSR && csr_done && csr_claimed &&
    csr_read |=> !unclaimed_read_flag)
    else $error("claimed read left the flag set");

  AST_EE_ADDRESS: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_ee_decode |=> ee_req && ee_byte_addr == {$past(dec_b4),
                                               $past(dec_b3)})
    else $error("eeprom byte address badly formed");

  AST_EE_DEVICE: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_ee_decode |=> ee_dev_addr == ($past(cmd[1]) ? $past(dec_b2[7:1])
                                    : $past(default_ee_addr)))
    else $error("eeprom device address choice wrong");

  AST_RESERVED_FAMILY: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    state == smbus_cmd_pkg::ST_DECODE && family > 3'h1
    |=> state == smbus_cmd_pkg::ST_REPLY && !csr_req && !ee_req)
    else $error("reserved family started an access");

  AST_ARB_LIMIT: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    arb_count == 5'h0f && ee_arb_lost && !ee_arb_won
    |=> lost_arbitration_error)
    else $error("sixteenth lost arbitration not flagged");
endmodule
`default_nettype wire

/* link_host.sv */
// smbus host model driving the link side of the decoder
`default_nettype none
module link_host (
  input wire logic link_clk,
  output logic frame_start,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic frame_stop,
  output logic tx_req,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {frame_start, rx_valid, frame_stop, tx_req} = 4'h0;
    rx_byte = 8'h00;
  end
  task automatic write_frame(input logic [7:0] b[$]);
    @(posedge link_clk) frame_start <= 1'b1;
    foreach (b[i]) begin
      @(posedge link_clk) frame_start <= 1'b0;
      rx_valid <= 1'b1;
      rx_byte <= b[i];
    end
    @(posedge link_clk) rx_valid <= 1'b0;
    frame_stop <= 1'b1;
    // released data line must not look like a held byte
    rx_byte <= ~rx_byte;
    @(posedge link_clk) frame_stop <= 1'b0;
  endtask
  task automatic read_start();
    @(posedge link_clk) frame_start <= 1'b1;
    @(posedge link_clk) frame_start <= 1'b0;
  endtask
  task automatic read_byte(output logic [7:0] d);
    @(posedge link_clk) tx_req <= 1'b1;
    @(posedge link_clk) tx_req <= 1'b0;
    #1 d = tx_valid ? tx_byte : 8'hxx;
  endtask
endmodule
`default_nettype wire

/* smbus_slave_cmd_decode_bench.sv */
// self-checking bench for the slave smbus command decoder
`default_nettype none
module smbus_slave_cmd_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b1;
  logic reset_n = 1'b0;
  logic link_reset_n = 1'b0;
  logic csr_done = 1'b0, csr_claimed = 1'b0, ee_done = 1'b0;
  logic ee_nack = 1'b0, ee_misplaced = 1'b0, ee_arb_lost = 1'b0;
  logic ee_arb_won = 1'b0;
  logic [31:0] csr_rdata = 32'h0, csr_wdata;
  logic [7:0] ee_rdata = 8'h00, rx_byte, tx_byte, ee_wdata;
  logic [6:0] default_ee_addr = 7'h50, ee_dev_addr;
  logic [13:0] csr_addr;
  logic [15:0] ee_byte_addr;
  logic [3:0] csr_be;
  logic frame_start, rx_valid, frame_stop, tx_req, rx_nack, tx_valid;
  logic tx_nack, csr_req, csr_read, ee_req, ee_read, cmd_busy;
  logic unclaimed_read_flag, unclaimed_write_flag, no_ack_error;
  logic lost_arbitration_error, misplaced_condition_error;
  int errors = 0;
  int total_checks = 0;
  smbus_slave_cmd_decode smbus_slave_cmd_decode_i (.*);
  link_host link_host_i (.*);
  always #25 ref_clk = ~ref_clk;
  always #6 link_clk = ~link_clk;
  task automatic conclude();
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic cond(input int w);
    return w == 0 ? csr_req : w == 1 ? ee_req : !cmd_busy;
  endfunction
  // 0 csr request, 1 eeprom request, 2 decoder idle
  task automatic wait_for(input int w);
    int n;
    n = 0;
    while (cond(w) !== 1'b1) begin
      @(posedge ref_clk) #1 n++;
      if (n > 300) begin
        errors++;
        conclude();
      end
    end
  endtask
  task automatic respond(input logic ee, input logic ok,
    input logic [31:0] rd, input logic [1:0] err);
    @(posedge ref_clk) csr_done <= !ee;
    ee_done <= ee;
    csr_claimed <= ok;
    csr_rdata <= rd;
    ee_rdata <= rd[7:0];
    {ee_misplaced, ee_nack} <= err;
    @(posedge ref_clk) {csr_done, ee_done, ee_nack, ee_misplaced} <= 4'h0;
    csr_rdata <= ~rd;
    wait_for(2);
    // link side only sees the finish a few link cycles later
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic read_expect(input logic [7:0] e[$]);
    logic [7:0] d;
    link_host_i.read_start();
    foreach (e[i]) begin
      link_host_i.read_byte(d);
      check(d, e[i]);
    end
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge link_clk) link_reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    link_host_i.write_frame('{8'h40, 8'h07, 8'h05, 8'h34, 8'hc2, 8'h11,
      8'h22, 8'h33, 8'h44});
    wait_for(0);
    check(csr_read, 1'b0);
    check(csr_addr, 14'h0234);
    check(csr_be, 4'h5);
    check(csr_wdata, 32'h00330011);
    // second command while the first is pending is refused
    link_host_i.write_frame('{8'h00, 8'h1f, 8'h00, 8'h00});
    check(rx_nack, 1'b1);
    read_expect('{8'h00});
    check(tx_nack, 1'b1);
    respond(1'b0, 1'b0, 32'h0, 2'h0);
    check(unclaimed_write_flag, 1'b1);
    link_host_i.write_frame('{8'h00, 8'h1f, 8'h78, 8'h01});
    wait_for(0);
    check(csr_read, 1'b1);
    respond(1'b0, 1'b0, 32'hdeadbeef, 2'h0);
    check(unclaimed_read_flag, 1'b1);
    read_expect('{8'hdf, 8'h78, 8'h01, 8'hef});
    repeat (10) @(posedge ref_clk);
    check({unclaimed_read_flag, unclaimed_write_flag}, 2'h0);
    link_host_i.write_frame('{8'h44, 8'h04, 8'h03, 8'ha4, 8'h78, 8'h56});
    wait_for(1);
    check({ee_read, ee_dev_addr, ee_byte_addr}, 24'hd25678);
    respond(1'b1, 1'b0, 32'h5a, 2'h1);
    check(no_ack_error, 1'b1);
    read_expect('{8'h05, 8'h0b, 8'ha4, 8'h78, 8'h56, 8'h5a});
    check(tx_nack, 1'b0);
    link_host_i.write_frame('{8'h04, 8'h00, 8'ha4, 8'hcd, 8'hab, 8'h9a});
    wait_for(1);
    check({ee_read, ee_dev_addr, ee_byte_addr, ee_wdata},
      32'h50abcd9a);
    repeat (16) @(posedge ref_clk) ee_arb_lost <= 1'b1;
    @(posedge ref_clk) ee_arb_lost <= 1'b0;
    respond(1'b1, 1'b1, 32'h0, 2'h2);
    check({lost_arbitration_error, misplaced_condition_error},
      2'h3);
    // claimed read: flag stays clear, disabled lanes read as zero
    link_host_i.write_frame('{8'h00, 8'h12, 8'h00, 8'h00});
    wait_for(0);
    respond(1'b0, 1'b1, 32'h12345678, 2'h0);
    check(unclaimed_read_flag, 1'b0);
    read_expect('{8'h12, 8'h00, 8'h00, 8'h00, 8'h56});
    // reserved family: no access and an empty reply
    link_host_i.write_frame('{8'h08});
    repeat (10) @(posedge ref_clk);
    check({csr_req, ee_req, cmd_busy}, 3'h0);
    read_expect('{8'h00});
    check(tx_nack, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
